// file: rtl/spio_regs.vh
// constants for the scale plc integer slot io block
// ****************************************************************
// Operation
// - two in, two out words per slot
// - weight word is signed selected quantity
// - select code picks value, above five gross
// - status bits 0-2 show target comparison
// - comparator bits follow comparator state
// - enter bit set, cleared by display change
// - bits 9-11 mirror internal inputs
// - bit 12 shows motion
// - bit 13 shows net mode
// - bit 14 marks update, plc ignores data
// - bit 15 data ok, else weight zero
// - load tare edge copies value, net mode
// - clear tare edge zeroes tare, gross
// - tare edge tares weight unless moving
// - print edge prints, zero edge rezeroes
// - target bit starts rise, aborts fall
// - display field leaving zero posts message
// - command bits 12-14 drive free outputs
// - load target edge copies value
// - commands only slot one, select everywhere
// ****************************************************************
`ifndef SPIO_REGS_VH
`define SPIO_REGS_VH
`define SPIO_NUM_SLOTS 4
`define SPIO_SEL_LSB 0
`define SPIO_SEL_MSB 2
`define SPIO_SEL_GROSS 3'h0
`define SPIO_SEL_NET 3'h1
`define SPIO_SEL_DISP 3'h2
`define SPIO_SEL_TARE 3'h3
`define SPIO_SEL_TARGET 3'h4
`define SPIO_SEL_RATE 3'h5
`define SPIO_CMD_LOAD_TARE 3
`define SPIO_CMD_CLR_TARE 4
`define SPIO_CMD_TARE 5
`define SPIO_CMD_PRINT 6
`define SPIO_CMD_ZERO 7
`define SPIO_CMD_TARGET 8
`define SPIO_CMD_MSG_LSB 9
`define SPIO_CMD_MSG_MSB 11
`define SPIO_CMD_OUT_LSB 12
`define SPIO_CMD_OUT_MSB 14
`define SPIO_CMD_LOAD_TGT 15
`define SPIO_ST_ENTER 8
`define SPIO_ST_MOTION 12
`define SPIO_ST_NET 13
`define SPIO_ST_UPDATE 14
`define SPIO_ST_OK 15
`define SPIO_WORD_RST 16'h0000
`define SPIO_MSG_RST 3'h0
`define SPIO_MSG_PROMPT 3'h6
`endif

// file: rtl/spio_slot_io.v
// slot process-data mapper for the integer and divisions plc format
`timescale 1ns/1ps
`default_nettype none
`include "spio_regs.vh"
module spio_slot_io
(
    input wire clk_in, // 125 MHz system clock
    input wire nrst_in, // async reset, active low
    input wire ce_in, // clock enable, freezes state when low
    input wire update_in, // interface update cycle tick, one pulse
    input wire [63:0] value_words_in, // plc value word per slot
    input wire [63:0] cmd_words_in, // plc command word per slot
    input wire [1:0] rd_slot_in, // slot picked for the read port
    output wire [15:0] weight_word_out, // weight word of rd_slot_in
    output wire [15:0] status_word_out, // status word of rd_slot_in
    output reg update_busy_out, // refresh in progress
    input wire [15:0] gross_in, // gross weight
    input wire [15:0] net_in, // net weight
    input wire [15:0] disp_in, // displayed weight
    input wire [15:0] tare_in, // present tare register
    input wire [15:0] rate_in, // rate
    input wire [2:0] target_cmp_in, // target comparison bits
    input wire [4:0] comparator_in, // comparator 1..5 states
    input wire enter_key_in, // keypad enter, async pin
    input wire [2:0] hw_inputs_in, // internal inputs, async pins
    input wire motion_in, // scale unstable
    input wire net_mode_in, // scale in net mode
    input wire data_ok_in, // normal operating conditions
    input wire [2:0] out_owned_in, // outputs claimed by local logic
    input wire [2:0] local_out_in, // local logic output values
    output reg [15:0] tare_value_out, // value for tare register
    output reg load_tare_out, // load tare pulse
    output reg clear_tare_out, // clear tare pulse
    output reg tare_now_out, // tare present weight pulse
    output reg print_out, // print request pulse
    output reg zero_out, // re-zero request pulse
    output reg target_start_out, // target start pulse
    output reg target_abort_out, // target abort pulse
    output reg [15:0] target_value_out, // target register
    output reg [2:0] message_code_variable_out, // posted message code
    output reg message_post_out, // message posted pulse
    output reg prompt_sequence_trigger_out, // prompt start pulse
    output reg [2:0] disc_out // internal discrete outputs
);
    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    reg [3:0] pin_s1_r; // first stage, read only by second
    reg [3:0] pin_s2_r; // second stage
    reg enter_q_r; // enter level of previous cycle

    // async pins pass two flops before use
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
            enter_q_r <= 1'b0;
        end
        else if (ce_in)
        begin
            pin_s1_r <= {hw_inputs_in, enter_key_in};
            pin_s2_r <= pin_s1_r;
            enter_q_r <= pin_s2_r[0];
        end
    end

    wire enter_rise = pin_s2_r[0] & ~enter_q_r; // one press event

    // ****************************************************************
    // helpers
    // ****************************************************************
    // value chosen by a select code; codes above five report gross
    function [15:0] sel_value;
        input [2:0] sel;
        input [15:0] g, n, d, t, tg, r;
        begin
            case (sel)
                `SPIO_SEL_NET: sel_value = n;
                `SPIO_SEL_DISP: sel_value = d;
                `SPIO_SEL_TARE: sel_value = t;
                `SPIO_SEL_TARGET: sel_value = tg;
                `SPIO_SEL_RATE: sel_value = r;
                default: sel_value = g; // gross and 6, 7
            endcase
        end
    endfunction

    // a 0 to 1 change of one bit between two command words
    function rise;
        input [15:0] now;
        input [15:0] prev;
        input integer b;
        begin
            rise = now[b] & ~prev[b];
        end
    endfunction

    // ****************************************************************
    // command edge detection, slot one only
    // ****************************************************************
    reg [15:0] cmd_prev_r; // slot one command at last update
    reg enter_flag_r; // sticky enter status
    wire [15:0] cmd0 = cmd_words_in[15:0];
    wire [2:0] msg_now = cmd0[`SPIO_CMD_MSG_MSB:`SPIO_CMD_MSG_LSB];
    wire [2:0] msg_prev =
        cmd_prev_r[`SPIO_CMD_MSG_MSB:`SPIO_CMD_MSG_LSB];
    wire msg_change = update_in & (msg_now != msg_prev);

    // pulses last one cycle, raised on the update tick
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            cmd_prev_r <= `SPIO_WORD_RST;
            tare_value_out <= `SPIO_WORD_RST;
            target_value_out <= `SPIO_WORD_RST;
            load_tare_out <= 1'b0;
            clear_tare_out <= 1'b0;
            tare_now_out <= 1'b0;
            print_out <= 1'b0;
            zero_out <= 1'b0;
            target_start_out <= 1'b0;
            target_abort_out <= 1'b0;
            message_code_variable_out <= `SPIO_MSG_RST;
            message_post_out <= 1'b0;
            prompt_sequence_trigger_out <= 1'b0;
        end
        else if (ce_in)
        begin
            load_tare_out <= 1'b0;
            clear_tare_out <= 1'b0;
            tare_now_out <= 1'b0;
            print_out <= 1'b0;
            zero_out <= 1'b0;
            target_start_out <= 1'b0;
            target_abort_out <= 1'b0;
            message_post_out <= 1'b0;
            prompt_sequence_trigger_out <= 1'b0;
            if (update_in)
            begin
                cmd_prev_r <= cmd0;
                // value word copied into tare, net mode follows
                if (rise(cmd0, cmd_prev_r, `SPIO_CMD_LOAD_TARE))
                begin
                    tare_value_out <= value_words_in[15:0];
                    load_tare_out <= 1'b1;
                end
                clear_tare_out <=
                    rise(cmd0, cmd_prev_r, `SPIO_CMD_CLR_TARE);
                // motion blocks the tare; plc resends after timeout
                tare_now_out <= rise(cmd0, cmd_prev_r, `SPIO_CMD_TARE) &
                    ~motion_in;
                print_out <=
                    rise(cmd0, cmd_prev_r, `SPIO_CMD_PRINT);
                zero_out <=
                    rise(cmd0, cmd_prev_r, `SPIO_CMD_ZERO);
                target_start_out <=
                    rise(cmd0, cmd_prev_r, `SPIO_CMD_TARGET);
                target_abort_out <=
                    rise(cmd_prev_r, cmd0, `SPIO_CMD_TARGET);
                if (rise(cmd0, cmd_prev_r, `SPIO_CMD_LOAD_TGT))
                    target_value_out <= value_words_in[15:0];
                // only leaving zero starts a new message
                if (msg_prev == `SPIO_MSG_RST && msg_now != `SPIO_MSG_RST)
                begin
                    message_code_variable_out <= msg_now;
                    message_post_out <= 1'b1;
                    prompt_sequence_trigger_out <=
                        (msg_now == `SPIO_MSG_PROMPT);
                end
            end
        end
    end

    // ****************************************************************
    // enter flag and discrete outputs
    // ****************************************************************
    // set wins over a clear arriving in the same cycle
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            enter_flag_r <= 1'b0;
            disc_out <= 3'h0;
        end
        else if (ce_in)
        begin
            if (enter_rise)
                enter_flag_r <= 1'b1;
            else if (msg_change)
                enter_flag_r <= 1'b0;
            // owned outputs stay with local logic
            disc_out <= (out_owned_in & local_out_in) |
                (~out_owned_in &
                cmd0[`SPIO_CMD_OUT_MSB:`SPIO_CMD_OUT_LSB]);
        end
    end

    // ****************************************************************
    // per slot word builder, one slot a cycle
    // ****************************************************************
    localparam ST_IDLE = 2'b01; // waiting for update
    localparam ST_FILL = 2'b10; // writing slots
    reg [1:0] state_r; // one-hot state
    reg [1:0] slot_r; // slot being written
    reg [15:0] wt_nxt; // weight word for slot_r
    reg [15:0] st_nxt; // status word for slot_r
    reg [2:0] sel_cur; // select code of slot_r

    // compose the two input words for slot_r
    always @*
    begin
        sel_cur = 3'h0;
        case (slot_r)
            2'd0: sel_cur = cmd_words_in[2:0];
            2'd1: sel_cur = cmd_words_in[18:16];
            2'd2: sel_cur = cmd_words_in[34:32];
            default: sel_cur = cmd_words_in[50:48];
        endcase
        // bad conditions force a zero weight
        wt_nxt = data_ok_in ? sel_value(sel_cur, gross_in, net_in,
            disp_in, tare_in, target_value_out, rate_in) :
            `SPIO_WORD_RST;
        st_nxt = `SPIO_WORD_RST;
        st_nxt[2:0] = target_cmp_in;
        st_nxt[7:3] = {comparator_in[0], comparator_in[1],
            comparator_in[2], comparator_in[3], comparator_in[4]};
        st_nxt[`SPIO_ST_ENTER] = enter_flag_r;
        st_nxt[11:9] = pin_s2_r[3:1];
        st_nxt[`SPIO_ST_MOTION] = motion_in;
        st_nxt[`SPIO_ST_NET] = net_mode_in;
        st_nxt[`SPIO_ST_UPDATE] = 1'b0; // busy is overlaid on read
        st_nxt[`SPIO_ST_OK] = data_ok_in;
    end

    // walk all slots after each update tick seen while idle
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_r <= ST_IDLE;
            slot_r <= 2'd0;
            update_busy_out <= 1'b1;
        end
        else if (ce_in)
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (update_in)
                    begin
                        state_r <= ST_FILL;
                        slot_r <= 2'd0;
                        update_busy_out <= 1'b1;
                    end
                    else
                        update_busy_out <= 1'b0;
                end
                ST_FILL:
                begin
                    slot_r <= slot_r + 2'd1;
                    if (slot_r == 2'd3)
                        state_r <= ST_IDLE;
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    wire [31:0] rd_word; // registered read data
    spio_slot_mem u_mem
    (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .we_in(state_r == ST_FILL),
        .waddr_in(slot_r),
        .wdata_in({st_nxt, wt_nxt}),
        .raddr_in(rd_slot_in),
        .rdata_out(rd_word)
    );

    assign weight_word_out = rd_word[15:0];
    // busy flag warns the plc that words may be mixed
    assign status_word_out = rd_word[31:16] |
        {1'b0, update_busy_out, 14'h0000};
endmodule // spio_slot_io
`default_nettype wire

// file: rtl/spio_slot_mem.v
// small register memory holding the per-slot weight and status words
`timescale 1ns/1ps
`default_nettype none
module spio_slot_mem
(
    input wire clk_in, // system clock
    input wire nrst_in, // async reset, active low
    input wire ce_in, // clock enable
    input wire we_in, // write strobe
    input wire [1:0] waddr_in, // write slot
    input wire [31:0] wdata_in, // status and weight word
    input wire [1:0] raddr_in, // read slot
    output reg [31:0] rdata_out // registered read data
);
    // storage, one word pair per slot
    reg [31:0] mem_r [0:3];
    integer i;

    // write port and registered read port
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            for (i = 0; i < 4; i = i + 1)
                mem_r[i] <= 32'h0000_0000;
            rdata_out <= 32'h0000_0000;
        end
        else if (ce_in)
        begin
            if (we_in)
                mem_r[waddr_in] <= wdata_in;
            rdata_out <= mem_r[raddr_in];
        end
    end
endmodule // spio_slot_mem
`default_nettype wire

// file: test/spio_plc_model.sv
// plc master model exchanging cyclic slot words
`timescale 1ns/1ps
`default_nettype none
module spio_plc_model
(
    input wire logic clk_in, // clock
    input wire logic busy_in, // update in process flag
    output logic update_out, // update tick
    output logic [63:0] value_out, // value word per slot
    output logic [63:0] cmd_out, // command word per slot
    output logic hung_out // refresh wait ran out
);
    initial
    begin
        update_out = 1'b0;
        value_out = 64'h0000_0000_0000_0000;
        cmd_out = 64'h0000_0000_0000_0000;
        hung_out = 1'b0;
    end
    // one exchange: value first, then command with the tick
    task xfer(input logic [1:0] s, input logic [15:0] v, input logic [15:0] c);
        int i;
        begin
            @(posedge clk_in) value_out[16*s +: 16] <= v;
            @(posedge clk_in) cmd_out[16*s +: 16] <= c;
            update_out <= 1'b1;
            @(posedge clk_in) update_out <= 1'b0;
            // slot data is not trusted until the refresh flag drops
            for (i = 0; i < 20; i++)
            begin
                @(posedge clk_in);
                #1;
                if (busy_in === 1'b0)
                    break;
            end
            if (busy_in !== 1'b0)
                hung_out <= 1'b1;
        end
    endtask
endmodule // spio_plc_model
`default_nettype wire

// file: test/spio_slot_io_sva.sv
// assertion checker for the slot io mapper
`timescale 1ns/1ps
`default_nettype none
module spio_slot_io_sva
(
    input wire clk_in, // clock
    input wire nrst_in, // reset, active low
    input wire ce_in, // clock enable
    input wire update_in, // update tick
    input wire [63:0] value_words_in, // value words
    input wire [63:0] cmd_words_in, // command words
    input wire motion_in, // scale moving
    input wire [2:0] out_owned_in, // owned outputs
    input wire [2:0] local_out_in, // local values
    input wire [15:0] status_word_out, // status word
    input wire update_busy_out, // refresh flag
    input wire [15:0] tare_value_out, // tare value
    input wire [15:0] target_value_out, // target value
    input wire load_tare_out, // load tare pulse
    input wire clear_tare_out, // clear pulse
    input wire tare_now_out, // tare pulse
    input wire print_out, // print pulse
    input wire zero_out, // zero pulse
    input wire target_start_out, // start pulse
    input wire target_abort_out, // abort pulse
    input wire [2:0] message_code_variable_out, // message code
    input wire message_post_out, // post pulse
    input wire prompt_sequence_trigger_out, // prompt pulse
    input wire [2:0] disc_out // discrete outputs
);
    // ****************************************************************
    // helper: slot one command held from the last accepted update
    // ****************************************************************
    reg [15:0] prev_r; // command at last update
    wire tick = ce_in && update_in; // accepted update
    wire [15:0] cmd = cmd_words_in[15:0]; // slot one command
    wire [15:0] rise = tick ? cmd & ~prev_r : 16'h0000; // 0 to 1
    wire [15:0] fall = tick ? ~cmd & prev_r : 16'h0000; // 1 to 0
    wire msg_go = tick && prev_r[11:9] == 3'h0 && cmd[11:9] != 3'h0;
    // latch only at updates so edges span whole update cycles
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            prev_r <= 16'h0000;
        else if (tick)
            prev_r <= cmd;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_busy_run;
        update_busy_out [*5] ##1 !update_busy_out;
    endsequence
    a_busy_window: assert property (tick |=> s_busy_run)
        else $error("refresh flag window wrong");
    a_busy_status: assert property (
        status_word_out[14] == update_busy_out)
        else $error("status update bit differs from refresh flag");
    a_load_tare: assert property (rise[3] |=> load_tare_out &&
        tare_value_out == $past(value_words_in[15:0]))
        else $error("tare load missing");
    a_tare_cause: assert property (load_tare_out |-> $past(rise[3]))
        else $error("tare load without edge");
    a_clear_tare: assert property (rise[4] |=> clear_tare_out)
        else $error("clear tare missing");
    a_tare_motion: assert property ($past(ce_in) |->
        tare_now_out == $past(rise[5] && !motion_in))
        else $error("tare taken in motion or without edge");
    a_print_zero: assert property (tick |=>
        {zero_out, print_out} == $past(rise[7:6]))
        else $error("print or zero pulse wrong");
    a_target_run: assert property (tick |=>
        {target_abort_out, target_start_out} == $past({fall[8], rise[8]}))
        else $error("target start or abort wrong");
    a_load_target: assert property (rise[15] |=>
        target_value_out == $past(value_words_in[15:0]))
        else $error("target load wrong");
    a_msg_post: assert property (msg_go |=> message_post_out &&
        message_code_variable_out == $past(cmd[11:9]) &&
        prompt_sequence_trigger_out == ($past(cmd[11:9]) == 3'h6))
        else $error("message post wrong");
    a_disc_follow: assert property ($past(ce_in) |-> disc_out ==
        $past(local_out_in & out_owned_in | cmd[14:12] & ~out_owned_in))
        else $error("discrete outputs wrong");
endmodule // spio_slot_io_sva
bind spio_slot_io spio_slot_io_sva u_sva (.clk_in(clk_in), .nrst_in(nrst_in),
    .ce_in(ce_in), .update_in(update_in), .value_words_in(value_words_in),
    .cmd_words_in(cmd_words_in), .motion_in(motion_in),
    .out_owned_in(out_owned_in), .local_out_in(local_out_in),
    .status_word_out(status_word_out), .update_busy_out(update_busy_out),
    .tare_value_out(tare_value_out), .target_value_out(target_value_out),
    .load_tare_out(load_tare_out), .clear_tare_out(clear_tare_out),
    .tare_now_out(tare_now_out), .print_out(print_out), .zero_out(zero_out),
    .target_start_out(target_start_out), .target_abort_out(target_abort_out),
    .message_code_variable_out(message_code_variable_out),
    .message_post_out(message_post_out), .disc_out(disc_out),
    .prompt_sequence_trigger_out(prompt_sequence_trigger_out));
`default_nettype wire

// file: test/spio_slot_io_tb.sv
// self-checking bench for the slot io mapper
`timescale 1ns/1ps
`default_nettype none
module spio_slot_io_tb;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic clk_in = 1'b0; // 125 MHz clock
    logic nrst_in = 1'b0; // reset, active low
    logic [1:0] rd_slot_in = 2'h0; // read port slot
    logic [15:0] gross_in = 16'h0101, net_in = 16'h0202, disp_in = 16'h0303;
    logic [15:0] tare_in = 16'h0404, rate_in = 16'h0505, tgt_v, w, st;
    logic [2:0] target_cmp_in = 3'h5, hw_inputs_in = 3'h3; // status sources
    logic [4:0] comparator_in = 5'h06; // comparator states
    logic enter_key_in = 1'b0, motion_in = 1'b0, net_mode_in = 1'b1;
    logic data_ok_in = 1'b1, ce_in = 1'b1; // normal operation, running
    logic [2:0] out_owned_in = 3'h0, local_out_in = 3'h0; // local outputs
    wire [15:0] weight_word_out, status_word_out, tare_value_out;
    wire [15:0] target_value_out; // loaded target
    wire [63:0] value_words_in, cmd_words_in; // plc words
    wire [8:0] pls; // all one-cycle pulses
    wire [2:0] message_code_variable_out, disc_out; // code, outputs
    wire update_in, update_busy_out, hung; // tick, flag, timeout
    int num_errors, num_checks, i, cnt [0:8], ex [0:8];
    always #4 clk_in = ~clk_in;
    spio_plc_model plc (.clk_in(clk_in), .busy_in(update_busy_out),
        .update_out(update_in), .value_out(value_words_in),
        .cmd_out(cmd_words_in), .hung_out(hung));
    spio_slot_io DUT (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in),
        .update_in(update_in), .value_words_in(value_words_in),
        .cmd_words_in(cmd_words_in), .rd_slot_in(rd_slot_in),
        .weight_word_out(weight_word_out), .status_word_out(status_word_out),
        .update_busy_out(update_busy_out), .gross_in(gross_in),
        .net_in(net_in), .disp_in(disp_in), .tare_in(tare_in),
        .rate_in(rate_in), .target_cmp_in(target_cmp_in),
        .comparator_in(comparator_in), .enter_key_in(enter_key_in),
        .hw_inputs_in(hw_inputs_in), .motion_in(motion_in),
        .net_mode_in(net_mode_in), .data_ok_in(data_ok_in),
        .out_owned_in(out_owned_in), .local_out_in(local_out_in),
        .tare_value_out(tare_value_out), .load_tare_out(pls[0]),
        .clear_tare_out(pls[1]), .tare_now_out(pls[2]), .print_out(pls[3]),
        .zero_out(pls[4]), .target_start_out(pls[5]),
        .target_abort_out(pls[6]), .target_value_out(target_value_out),
        .message_code_variable_out(message_code_variable_out),
        .message_post_out(pls[7]), .prompt_sequence_trigger_out(pls[8]),
        .disc_out(disc_out));
    // count pulses so short ones are never missed
    always @(posedge clk_in)
    begin
        for (int k = 0; k < 9; k++)
            if (pls[k] === 1'b1)
                cnt[k] <= cnt[k] + 1;
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        begin
            num_checks++;
            if (seen !== exp)
            begin
                num_errors++;
                $display("wrong value %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // read port has one cycle of latency, so allow a margin
    task rd(input logic [1:0] s);
        begin
            @(posedge clk_in) rd_slot_in <= s;
            repeat (3) @(posedge clk_in);
            #1 w = weight_word_out;
            st = status_word_out;
        end
    endtask
    function logic [15:0] wexp(input logic [2:0] c);
        case (c)
            3'h1: wexp = net_in;
            3'h2: wexp = disp_in;
            3'h3: wexp = tare_in;
            3'h4: wexp = tgt_v;
            3'h5: wexp = rate_in;
            default: wexp = gross_in;
        endcase
    endfunction
    function logic [15:0] sexp(input logic ent);
        sexp = {data_ok_in, 1'b0, net_mode_in, motion_in, hw_inputs_in, ent,
            comparator_in[0], comparator_in[1], comparator_in[2],
            comparator_in[3], comparator_in[4], target_cmp_in};
    endfunction
    task conclude;
        begin
            $display("checks %0d errors %0d", num_checks, num_errors);
            if (num_errors == 0 && num_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    always @(posedge hung)
    begin
        num_errors++;
        conclude;
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        repeat (10) @(posedge clk_in);
        chk("busy_rst", update_busy_out, 1);
        chk("upd_bit_rst", status_word_out[14], 1);
        nrst_in <= 1'b1;
        tgt_v = 16'hf00d;
        plc.xfer(2'h0, tgt_v, 16'h8000);
        chk("target", target_value_out, tgt_v);
        for (i = 0; i < 8; i++)
        begin
            plc.xfer(2'h2, 16'h0000, 16'(i));
            plc.xfer(2'h0, 16'h0000, 16'(7 - i));
            rd(2'h0);
            chk("weight0", w, wexp(3'(7 - i)));
            rd(2'h2);
            chk("weight2", w, wexp(3'(i)));
            chk("status2", st, sexp(1'b0));
        end
        for (i = 3; i < 8; i++)
        begin
            plc.xfer(2'h0, 16'h0a0b, 16'h0001 << i);
            ex[i - 3]++;
            if (i == 3)
                chk("tare_val", tare_value_out, 16'h0a0b);
            plc.xfer(2'h0, 16'h0a0b, 16'h0000);
        end
        plc.xfer(2'h1, 16'h0a0b, 16'hfff8);
        plc.xfer(2'h1, 16'h0a0b, 16'h0000);
        chk("disc_slot2", disc_out, 3'h0);
        motion_in <= 1'b1;
        plc.xfer(2'h0, 16'h0000, 16'h0020);
        rd(2'h0);
        chk("st_motion", st, sexp(1'b0));
        plc.xfer(2'h0, 16'h0000, 16'h0000);
        motion_in <= 1'b0;
        plc.xfer(2'h0, 16'h0000, 16'h0100);
        plc.xfer(2'h0, 16'h0000, 16'h0000);
        ex[5]++;
        ex[6]++;
        for (i = 1; i < 8; i++)
        begin
            plc.xfer(2'h0, 16'h0000, 16'(i << 9));
            chk("msg_code", message_code_variable_out, i);
            ex[7]++;
            ex[8] += (i == 6);
            plc.xfer(2'h0, 16'h0000, 16'h0000);
        end
        plc.xfer(2'h0, 16'h0000, 16'h0600);
        plc.xfer(2'h0, 16'h0000, 16'h0a00);
        ex[7]++;
        chk("msg_held", message_code_variable_out, 3'h3);
        plc.xfer(2'h0, 16'h0000, 16'h0000);
        @(posedge clk_in) enter_key_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        enter_key_in <= 1'b0;
        plc.xfer(2'h0, 16'h0000, 16'h0000);
        rd(2'h0);
        chk("enter_set", st, sexp(1'b1));
        plc.xfer(2'h0, 16'h0000, 16'h0200);
        ex[7]++;
        plc.xfer(2'h0, 16'h0000, 16'h0000);
        rd(2'h0);
        chk("enter_clr", st, sexp(1'b0));
        data_ok_in <= 1'b0;
        plc.xfer(2'h0, 16'h0000, 16'h0000);
        rd(2'h0);
        chk("weight_bad", w, 16'h0000);
        chk("status_bad", st, sexp(1'b0));
        out_owned_in <= 3'h2;
        plc.xfer(2'h0, 16'h0000, 16'h5000);
        chk("disc_free", disc_out, 3'h5);
        plc.xfer(2'h0, 16'h0000, 16'h2000);
        chk("disc_owned", disc_out, 3'h0);
        // a frozen block must not latch the print edge it never saw
        ce_in <= 1'b0;
        plc.xfer(2'h0, 16'h0000, 16'h2040);
        ce_in <= 1'b1;
        plc.xfer(2'h0, 16'h0000, 16'h2000);
        chk("ce_frozen", cnt[3], 1);
        for (i = 0; i < 9; i++)
            chk("pulses", cnt[i], ex[i]);
        conclude;
    end
endmodule // spio_slot_io_tb
`default_nettype wire
